//--- design/eps_defs.vh
// constants for the enclave performance-monitor suppression block
// Functional notes
// - opt-out entry stops general counters and fixed counter zero; cycle counters keep running
// - no precise-event sampling records while inside an opt-out enclave
// - opt-out entry sets the interference flag, status bit 60
// - sibling all-thread counters count own thread only during opt-out enclave execution
// - enclave exit by exit leaf or async exit resumes all suppressed monitoring
// - on exit demoted sibling counters return to all-thread counting
// - supervisor enclave leaf records report that instruction's address
// - key-derive and report leaf records report the user enclave instruction address
// - opt-in enter/resume report user instruction address; opt-out enter/resume give none
// - pending event at exit leaf: opt-in exit address, opt-out last entry address
// - pending event after async exit: opt-in saved address, opt-out last entry address
// - second event after exiting-event delivery reports the async exit pointer
// - debug store faults reported at once; record skipped, may stay partial
// - faults storing records after async exit are dropped and generation aborted
// - traps on record stores are held until the next instruction boundary
// - after aborting records, delivery of the exiting event continues
// - opt-in enter, resume, exit, async exit each count one branch and instruction
// - opt-out enclave execution counts as one branch and one instruction
// - enclave entry leaves counters shared between cores untouched
// - interference flag clear means normal counting; set means counts may be affected
`ifndef EPS_DEFS_VH
`define EPS_DEFS_VH

// ==================================================
// register offsets (byte addresses)
`define EPS_OFF_CTRL      4'h0
`define EPS_OFF_ANYTHR    4'h4
`define EPS_OFF_STAT_HI   4'h8
`define EPS_OFF_STATE     4'hc

// ==================================================
// fields
`define EPS_CTRL_FIX0     4
`define EPS_CTRL_FIX1     5
`define EPS_CTRL_FIX2     6
`define EPS_CTRL_SAMPLE   7
`define EPS_CTRL_SHARED   8
`define EPS_FLAG_BIT      28
`define EPS_CTRL_RST      32'h0000_0000
`define EPS_ANYTHR_RST    32'h0000_0000

// ==================================================
// leaf kinds on leaf_kind_i
`define EPS_LEAF_SUPV     3'h0
`define EPS_LEAF_KEYREP   3'h1
`define EPS_LEAF_ENTER    3'h2
`define EPS_LEAF_RESUME   3'h3
`define EPS_LEAF_EXIT     3'h4
`define EPS_LEAF_OTHER    3'h5

`endif

//--- design/eps_top.v
// enclave entry/exit performance-monitor suppression with avalon-mm registers
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "eps_defs.vh"

module eps_top
#(
	parameter NUM_GP = 4,
	parameter ADDR_W = 64
)
(
	input  wire                ref_clk_i,
	input  wire                resetn_i,
	// avalon-mm slave
	input  wire [3:0]          avs_address_i,
	input  wire                avs_read_i,
	input  wire                avs_write_i,
	input  wire [31:0]         avs_writedata_i,
	input  wire [3:0]          avs_byteenable_i,
	output reg  [31:0]         avs_readdata_o,
	output reg                 avs_waitrequest_o,
	// core enclave sequencing
	input  wire                leaf_done_i,
	input  wire [2:0]          leaf_kind_i,
	input  wire                opt_out_i,
	input  wire [ADDR_W-1:0]   instr_addr_i,
	input  wire                async_exit_i,
	input  wire [ADDR_W-1:0]   save_area_addr_i,
	input  wire [ADDR_W-1:0]   exit_ptr_addr_i,
	input  wire                exit_event_done_i,
	input  wire                sample_pending_i,
	input  wire                sibling_opt_out_i,
	input  wire                store_area_fault_i,
	input  wire                store_area_trap_i,
	input  wire                record_store_done_i,
	input  wire                instr_boundary_i,
	// monitoring controls
	output reg  [NUM_GP-1:0]   gp_count_en_o,
	output reg                 fixed_zero_en_o,
	output reg                 fixed_cyc_one_en_o,
	output reg                 fixed_cyc_two_en_o,
	output reg                 shared_count_en_o,
	output reg                 sample_en_o,
	output reg  [NUM_GP+2:0]   sib_all_threads_o,
	output reg                 record_valid_o,
	output reg  [ADDR_W-1:0]   eventing_address_o,
	output reg                 branch_inc_o,
	output reg                 instr_inc_o,
	output reg                 fault_report_o,
	output reg                 record_abort_o,
	output reg                 trap_deliver_o,
	output reg                 exit_event_go_o
);

// ==================================================
// register decode
function is_off;
	input [3:0] a;
	input [3:0] off;
	begin
		is_off = (a == off);
	end
endfunction

reg  [31:0]       ctrl_q;
reg  [NUM_GP+2:0] anythr_q;
reg               flag_q;
reg               in_encl_q;
reg               opt_out_q;
reg  [ADDR_W-1:0] entry_addr_q;
reg               async_win_q;
reg               trap_pend_q;
reg               sec_pend_q;

wire req_w    = avs_read_i | avs_write_i;
wire take_w   = req_w & ~avs_waitrequest_o;
wire wr_w     = take_w & avs_write_i;

// one wait cycle: data prepared while waitrequest high, taken when low
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		avs_waitrequest_o <= 1'b1;
	else if (req_w && avs_waitrequest_o)
		avs_waitrequest_o <= 1'b0;
	else
		avs_waitrequest_o <= 1'b1;
end

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		avs_readdata_o <= 32'h0000_0000;
	else if (avs_read_i && avs_waitrequest_o)
	begin
		if (is_off(avs_address_i, `EPS_OFF_CTRL))
			avs_readdata_o <= ctrl_q;
		else if (is_off(avs_address_i, `EPS_OFF_ANYTHR))
			avs_readdata_o <= {{(29-NUM_GP){1'b0}}, anythr_q};
		else if (is_off(avs_address_i, `EPS_OFF_STAT_HI))
			avs_readdata_o <= {3'h0, flag_q, 28'h000_0000};
		else if (is_off(avs_address_i, `EPS_OFF_STATE))
			avs_readdata_o <= {28'h000_0000, trap_pend_q, async_win_q,
				opt_out_q, in_encl_q};
		else
			avs_readdata_o <= 32'h0000_0000;
	end
end

// ==================================================
// control registers with byte enables
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1)
	begin : g_ctrl
		always @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				ctrl_q[gi*8+7:gi*8] <= 8'h00;
			else if (wr_w && is_off(avs_address_i, `EPS_OFF_CTRL) && avs_byteenable_i[gi])
				ctrl_q[gi*8+7:gi*8] <= avs_writedata_i[gi*8+7:gi*8];
		end
	end
endgenerate

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		anythr_q <= {(NUM_GP+3){1'b0}};
	else if (wr_w && is_off(avs_address_i, `EPS_OFF_ANYTHR) && avs_byteenable_i[0])
		anythr_q <= avs_writedata_i[NUM_GP+2:0];
end

// ==================================================
// enclave mode tracking
wire is_entry_w = leaf_done_i &&
	(leaf_kind_i == `EPS_LEAF_ENTER || leaf_kind_i == `EPS_LEAF_RESUME);
wire is_exit_w  = leaf_done_i && (leaf_kind_i == `EPS_LEAF_EXIT);
wire leave_w    = (is_exit_w || async_exit_i) && in_encl_q;
wire oo_entry_w = is_entry_w && opt_out_i;
wire flag_clr_w = wr_w && is_off(avs_address_i, `EPS_OFF_STAT_HI) &&
	avs_byteenable_i[3] && avs_writedata_i[`EPS_FLAG_BIT];

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		in_encl_q    <= 1'b0;
		opt_out_q    <= 1'b0;
		entry_addr_q <= {ADDR_W{1'b0}};
	end
	else if (is_entry_w)
	begin
		in_encl_q    <= 1'b1;
		opt_out_q    <= opt_out_i;
		entry_addr_q <= instr_addr_i;
	end
	else if (leave_w)
	begin
		in_encl_q    <= 1'b0;
		opt_out_q    <= 1'b0;
	end
end

// set wins over the write-one clear
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		flag_q <= 1'b0;
	else if (oo_entry_w)
		flag_q <= 1'b1;
	else if (flag_clr_w)
		flag_q <= 1'b0;
end

wire supp_w = in_encl_q & opt_out_q;

// ==================================================
// counter enables; lag entry by two cycles
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		gp_count_en_o      <= {NUM_GP{1'b0}};
		fixed_zero_en_o    <= 1'b0;
		fixed_cyc_one_en_o <= 1'b0;
		fixed_cyc_two_en_o <= 1'b0;
		shared_count_en_o  <= 1'b0;
		sample_en_o        <= 1'b0;
		sib_all_threads_o  <= {(NUM_GP+3){1'b0}};
	end
	else
	begin
		gp_count_en_o      <= ctrl_q[NUM_GP-1:0] & {NUM_GP{~supp_w}};
		fixed_zero_en_o    <= ctrl_q[`EPS_CTRL_FIX0] & ~supp_w;
		fixed_cyc_one_en_o <= ctrl_q[`EPS_CTRL_FIX1];
		fixed_cyc_two_en_o <= ctrl_q[`EPS_CTRL_FIX2];
		shared_count_en_o  <= ctrl_q[`EPS_CTRL_SHARED];
		sample_en_o        <= ctrl_q[`EPS_CTRL_SAMPLE] & ~supp_w;
		// sibling mode is logic on this clock, no sync needed
		sib_all_threads_o  <= anythr_q & {(NUM_GP+3){~sibling_opt_out_i}};
	end
end

// ==================================================
// precise-event records and eventing address
reg              rec_d;
reg [ADDR_W-1:0] addr_d;

always @*
begin
	rec_d  = 1'b0;
	addr_d = instr_addr_i;
	if (exit_event_done_i && sec_pend_q)
	begin
		rec_d  = 1'b1;
		addr_d = exit_ptr_addr_i;
	end
	else if (async_exit_i && in_encl_q && sample_pending_i)
	begin
		rec_d  = 1'b1;
		addr_d = opt_out_q ? entry_addr_q : save_area_addr_i;
	end
	else if (leaf_done_i && sample_pending_i && ctrl_q[`EPS_CTRL_SAMPLE])
	begin
		case (leaf_kind_i)
			`EPS_LEAF_SUPV:
				rec_d = 1'b1;
			`EPS_LEAF_KEYREP:
				rec_d = ~supp_w;
			`EPS_LEAF_ENTER, `EPS_LEAF_RESUME:
				rec_d = ~opt_out_i;
			`EPS_LEAF_EXIT:
			begin
				rec_d  = 1'b1;
				addr_d = (in_encl_q && opt_out_q) ? entry_addr_q : instr_addr_i;
			end
			default:
				rec_d = ~supp_w;
		endcase
	end
end

// second event pended while the exiting event is delivered
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		sec_pend_q <= 1'b0;
	else if (async_win_q && sample_pending_i && !exit_event_done_i)
		sec_pend_q <= 1'b1;
	else if (exit_event_done_i)
		sec_pend_q <= 1'b0;
end

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		record_valid_o     <= 1'b0;
		eventing_address_o <= {ADDR_W{1'b0}};
	end
	else
	begin
		record_valid_o <= rec_d;
		if (rec_d)
			eventing_address_o <= addr_d;
	end
end

// ==================================================
// branch and instruction counting
reg cnt_d;

always @*
begin
	cnt_d = 1'b0;
	if (is_entry_w && !opt_out_i)
		cnt_d = 1'b1;
	else if (leave_w)
		cnt_d = 1'b1;
end

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		branch_inc_o <= 1'b0;
		instr_inc_o  <= 1'b0;
	end
	else
	begin
		branch_inc_o <= cnt_d;
		instr_inc_o  <= cnt_d;
	end
end

// ==================================================
// debug store faults and traps around async exit
// window spans record stores between async exit and exiting-event delivery
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		async_win_q <= 1'b0;
	else if (async_exit_i && in_encl_q)
		async_win_q <= 1'b1;
	else if (exit_event_done_i)
		async_win_q <= 1'b0;
end

always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		trap_pend_q <= 1'b0;
	else if (store_area_trap_i)
		trap_pend_q <= 1'b1;
	else if (instr_boundary_i)
		trap_pend_q <= 1'b0;
end

// fault while no event window: report now, record skipped (may be partial)
always @(posedge ref_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		fault_report_o <= 1'b0;
		record_abort_o <= 1'b0;
		trap_deliver_o <= 1'b0;
		exit_event_go_o <= 1'b0;
	end
	else
	begin
		fault_report_o <= store_area_fault_i & ~async_win_q;
		record_abort_o <= store_area_fault_i;
		trap_deliver_o <= trap_pend_q & instr_boundary_i;
		exit_event_go_o <= async_win_q & (store_area_fault_i | record_store_done_i);
	end
end

endmodule // eps_top

//--- verification/eps_props.sv
// assertion checker for the enclave monitor suppression block
`timescale 1ns/100ps
`include "eps_defs.vh"
// ==========
// checker
module eps_props
#(
	parameter NUM_GP = 4,
	parameter ADDR_W = 64
)
(
	input wire			ref_clk_i,
	input wire			resetn_i,
	input wire			avs_read_i,
	input wire			avs_write_i,
	input wire			avs_waitrequest_o,
	input wire			leaf_done_i,
	input wire [2:0]		leaf_kind_i,
	input wire			opt_out_i,
	input wire [ADDR_W-1:0]	instr_addr_i,
	input wire			sample_pending_i,
	input wire			sibling_opt_out_i,
	input wire			store_area_fault_i,
	input wire			store_area_trap_i,
	input wire			instr_boundary_i,
	input wire [NUM_GP-1:0]	gp_count_en_o,
	input wire			fixed_zero_en_o,
	input wire			fixed_cyc_one_en_o,
	input wire			shared_count_en_o,
	input wire			sample_en_o,
	input wire [NUM_GP+2:0]	sib_all_threads_o,
	input wire			record_valid_o,
	input wire [ADDR_W-1:0]	eventing_address_o,
	input wire			record_abort_o,
	input wire			trap_deliver_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	wire ent = leaf_done_i && leaf_kind_i == `EPS_LEAF_ENTER;
	property p_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer not one cycle");
	property p_sup;
		ent && opt_out_i |=> ##1 gp_count_en_o == 0 && !fixed_zero_en_o && !sample_en_o;
	endproperty
	a_sup: assert property (p_sup) else $error("counting not stopped");
	// writes excluded: a control write may move these enables legally
	property p_cyc;
		ent && !avs_write_i ##1 !avs_write_i |=> $stable(fixed_cyc_one_en_o) && $stable(shared_count_en_o);
	endproperty
	a_cyc: assert property (p_cyc) else $error("cycle or shared counter touched");
	property p_sib;
		sibling_opt_out_i |=> sib_all_threads_o == 0;
	endproperty
	a_sib: assert property (p_sib) else $error("sibling not demoted");
	property p_nrec;
		ent && opt_out_i |=> !record_valid_o;
	endproperty
	a_nrec: assert property (p_nrec) else $error("record on opt-out entry");
	property p_supv;
		leaf_done_i && leaf_kind_i == `EPS_LEAF_SUPV && sample_pending_i && sample_en_o
			|=> record_valid_o && eventing_address_o == $past(instr_addr_i);
	endproperty
	a_supv: assert property (p_supv) else $error("supervisor leaf address wrong");
	property p_flt;
		store_area_fault_i |=> record_abort_o;
	endproperty
	a_flt: assert property (p_flt) else $error("record not skipped on fault");
	property p_trp;
		store_area_trap_i && !instr_boundary_i |=> !trap_deliver_o;
	endproperty
	a_trp: assert property (p_trp) else $error("trap not held to boundary");
endmodule // eps_props

bind eps_top eps_props #(.NUM_GP(NUM_GP), .ADDR_W(ADDR_W)) u_props (.ref_clk_i, .resetn_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .leaf_done_i, .leaf_kind_i, .opt_out_i,
	.instr_addr_i, .sample_pending_i, .sibling_opt_out_i, .store_area_fault_i, .store_area_trap_i,
	.instr_boundary_i, .gp_count_en_o, .fixed_zero_en_o, .fixed_cyc_one_en_o,
	.shared_count_en_o, .sample_en_o, .sib_all_threads_o, .record_valid_o,
	.eventing_address_o, .record_abort_o, .trap_deliver_o);

//--- verification/eps_core_model.sv
// core enclave sequencing model: leaf completions and async exits
`timescale 1ns/100ps
`include "eps_defs.vh"
// ==========
// model
module eps_core_model
#(
	parameter ADDR_W = 64
)
(
	input  wire			ref_clk_i,
	output reg			leaf_done_o,
	output reg [2:0]		leaf_kind_o,
	output reg			opt_out_o,
	output reg [ADDR_W-1:0]	instr_addr_o,
	output reg			async_exit_o,
	output reg [ADDR_W-1:0]	save_area_addr_o,
	output reg [ADDR_W-1:0]	exit_ptr_addr_o
);
	initial
	begin
		{leaf_done_o, opt_out_o, async_exit_o} = 3'h0;
		leaf_kind_o = `EPS_LEAF_OTHER;
		// store area assumed resident and pre-marked, so no paging faults here
		{instr_addr_o, save_area_addr_o, exit_ptr_addr_o} = '0;
	end
	// address invalid after its pulse: inverted so a stale sample shows
	task leaf(input [2:0] k, input oo, input [ADDR_W-1:0] a);
		begin
			@(posedge ref_clk_i);
			leaf_done_o <= 1'b1;
			leaf_kind_o <= k;
			opt_out_o <= oo;
			instr_addr_o <= a;
			@(posedge ref_clk_i);
			leaf_done_o <= 1'b0;
			leaf_kind_o <= `EPS_LEAF_OTHER;
			instr_addr_o <= ~a;
		end
	endtask
	task async_exit(input [ADDR_W-1:0] s, input [ADDR_W-1:0] p);
		begin
			@(posedge ref_clk_i);
			async_exit_o <= 1'b1;
			save_area_addr_o <= s;
			exit_ptr_addr_o <= p;
			@(posedge ref_clk_i);
			async_exit_o <= 1'b0;
			save_area_addr_o <= ~s;
		end
	endtask
endmodule // eps_core_model

//--- verification/tb_top.sv
// self-checking bench for the enclave monitor suppression block
`timescale 1ns/100ps
`include "eps_defs.vh"
// ==========
// bench
module tb_top;
	logic ref_clk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic sample_pending_i = 1'b0, sibling_opt_out_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, q;
	logic [4:0] ev = 5'h0;
	logic [63:0] ea = 64'h0;
	wire avs_waitrequest_o, leaf_done_i, opt_out_i, async_exit_i, fixed_zero_en_o;
	wire fixed_cyc_one_en_o, fixed_cyc_two_en_o, shared_count_en_o, sample_en_o, record_valid_o;
	wire branch_inc_o, instr_inc_o, fault_report_o, record_abort_o, trap_deliver_o, exit_event_go_o;
	wire [2:0] leaf_kind_i;
	wire [3:0] gp_count_en_o;
	wire [6:0] sib_all_threads_o;
	wire [31:0] avs_readdata_o;
	wire [63:0] instr_addr_i, save_area_addr_i, exit_ptr_addr_i, eventing_address_o;
	wire [8:0] en = {shared_count_en_o, sample_en_o, fixed_cyc_two_en_o, fixed_cyc_one_en_o,
		fixed_zero_en_o, gp_count_en_o};
	wire [5:0] pv = {exit_event_go_o, trap_deliver_o, record_abort_o, fault_report_o, branch_inc_o,
		record_valid_o};
	int cnt [6] = '{default:0};
	int c0 [6] = '{default:0};
	int error_cnt = 0, n_compared = 0, cyc = 0;
	eps_top u_dut (.ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
		.leaf_done_i, .leaf_kind_i, .opt_out_i, .instr_addr_i, .async_exit_i, .save_area_addr_i,
		.exit_ptr_addr_i, .exit_event_done_i(ev[4]), .sample_pending_i, .sibling_opt_out_i,
		.store_area_fault_i(ev[0]), .store_area_trap_i(ev[1]), .record_store_done_i(ev[2]),
		.instr_boundary_i(ev[3]), .gp_count_en_o, .fixed_zero_en_o, .fixed_cyc_one_en_o,
		.fixed_cyc_two_en_o, .shared_count_en_o, .sample_en_o, .sib_all_threads_o,
		.record_valid_o, .eventing_address_o, .branch_inc_o, .instr_inc_o, .fault_report_o,
		.record_abort_o, .trap_deliver_o, .exit_event_go_o);
	eps_core_model u_core (.ref_clk_i, .leaf_done_o(leaf_done_i), .leaf_kind_o(leaf_kind_i),
		.opt_out_o(opt_out_i), .instr_addr_o(instr_addr_i), .async_exit_o(async_exit_i),
		.save_area_addr_o(save_area_addr_i), .exit_ptr_addr_o(exit_ptr_addr_i));
	always #4 ref_clk_i = ~ref_clk_i;
	// pulses counted on the falling edge, away from the launching edge
	always @(negedge ref_clk_i)
	begin
		for (int i = 0; i < 6; i++) if (pv[i] === 1'b1) cnt[i]++;
		if (record_valid_o === 1'b1) ea = eventing_address_o;
		chk(instr_inc_o, branch_inc_o);
	end
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			end_of_test;
		end
	end
	// ==========
	// helpers
	task chk(input [63:0] s, input [63:0] e);
		n_compared++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task dv(input int e [6]);
		for (int i = 0; i < 6; i++) chk(cnt[i] - c0[i], e[i]);
		c0 = cnt;
	endtask
	task idle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge ref_clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task rd(input [3:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task ep(input [4:0] m);
		@(posedge ref_clk_i);
		ev <= m;
		@(posedge ref_clk_i);
		ev <= 5'h0;
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========
	// scenarios
	task s_reg;
		rd(`EPS_OFF_CTRL, `EPS_CTRL_RST);
		rd(`EPS_OFF_ANYTHR, `EPS_ANYTHR_RST);
		rd(4'h2, 32'h0);
		bus(1'b1, `EPS_OFF_STATE, 32'hf);
		rd(`EPS_OFF_STATE, 32'h0);
		bus(1'b1, `EPS_OFF_CTRL, 32'h1ff);
		bus(1'b1, `EPS_OFF_ANYTHR, 32'h7f);
		rd(`EPS_OFF_CTRL, 32'h1ff);
	endtask
	task s_out;
		sample_pending_i <= 1'b1;
		u_core.leaf(`EPS_LEAF_ENTER, 1'b1, 64'h1000);
		rd(`EPS_OFF_STATE, 32'h3);
		chk(en, 9'h160);
		rd(`EPS_OFF_STAT_HI, 32'h1000_0000);
		dv('{0,0,0,0,0,0});
		u_core.leaf(`EPS_LEAF_EXIT, 1'b0, 64'h2000);
		rd(`EPS_OFF_STATE, 32'h0);
		chk(en, 9'h1ff);
		chk(ea, 64'h1000);
		dv('{1,1,0,0,0,0});
		bus(1'b1, `EPS_OFF_STAT_HI, 32'h1000_0000);
		rd(`EPS_OFF_STAT_HI, 32'h0);
	endtask
	task s_in;
		u_core.leaf(`EPS_LEAF_ENTER, 1'b0, 64'h3000);
		rd(`EPS_OFF_STATE, 32'h1);
		chk(ea, 64'h3000);
		u_core.leaf(`EPS_LEAF_EXIT, 1'b0, 64'h4000);
		idle(2);
		chk(ea, 64'h4000);
		dv('{2,2,0,0,0,0});
		for (int k = 0; k < 2; k++)
		begin
			u_core.leaf(3'(k), 1'b0, 64'h5000 + k);
			idle(2);
			chk(ea, 64'h5000 + k);
		end
		dv('{2,0,0,0,0,0});
	endtask
	task s_async;
		u_core.leaf(`EPS_LEAF_ENTER, 1'b0, 64'h6000);
		u_core.async_exit(64'h6100, 64'h6200);
		idle(2);
		chk(ea, 64'h6100);
		ep(5'h01);
		ep(5'h10);
		idle(2);
		chk(ea, 64'h6200);
		dv('{3,2,0,1,0,1});
		u_core.leaf(`EPS_LEAF_ENTER, 1'b1, 64'h7000);
		u_core.async_exit(64'h7100, 64'h7200);
		idle(2);
		chk(ea, 64'h7000);
		chk(en, 9'h1ff);
		ep(5'h10);
		sample_pending_i <= 1'b0;
		idle(2);
		dv('{2,1,0,0,0,0});
	endtask
	task s_store;
		ep(5'h01);
		idle(2);
		dv('{0,0,1,1,0,0});
		ep(5'h02);
		idle(3);
		dv('{0,0,0,0,0,0});
		ep(5'h08);
		idle(2);
		dv('{0,0,0,0,1,0});
		sibling_opt_out_i <= 1'b1;
		idle(2);
		chk(sib_all_threads_o, 7'h0);
		sibling_opt_out_i <= 1'b0;
		idle(2);
		chk(sib_all_threads_o, 7'h7f);
	endtask
	initial
	begin
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		s_reg;
		s_out;
		s_in;
		s_async;
		s_store;
		end_of_test;
	end
endmodule // tb_top
